// ==== voice_daa_ctrl_regs.sv ====
/*
 Control register bank for the voice line interface: mute, on-hook speed,
 filter type, ringer impedance, ring threshold, calibration, overload and
 billing tone control, reached over AXI4-Lite, with a sticky interrupt.
 Assumes line events arrive asynchronously and are held at least three
 sys_clk cycles; control outputs feed analog blocks on the same clock.
*/
// Our own choice: the AXI4-Lite register port.
// Function
// R1: Transmit mute bit set mutes transmit path; clear passes it.
// R2: Receive mute bit set mutes receive path; clear passes it.
// R3: On-hook speed bit, with remote bits, selects the on-hook time.
// R4: Filter select bit chooses FIR (0) or IIR (1) for both paths.
// R5: Ringer impedance bit: 0 high impedance, 1 synthesized impedance.
// R6: Two ring threshold bits select the ring detection window.
// R7: Software never programs ring threshold pattern 01; it is reserved.
// R8: With the simplest line-side part, software writes zero to bit 4.
// R9: Writing one to calibration clear discards stored ADC calibration.
// R10: Software writes calibration clear back to zero afterwards.
// R11: Writing one to manual calibration starts an ADC calibration.
// R12: Auto-calibration disable bit: 0 auto enabled, 1 disabled.
// R13: Bit 3 enables overload protection; software clears it before off-hook.
// R14: With billing tone enable set, stay off-hook through supply disruptions.
// R15: Detected billing tone sets the read-only billing tone flag.
// R16: Writing zero to billing tone enable also clears the flag.
// R17: Reserved bits 3 and 2 of line control one accept any write.
// R18: Receive overload sets flag; writing zero clears flag and interrupt bit.
// R19: Reserved bits in gain and line control one read as zero.
`timescale 1ns/1ps
`default_nettype none
module voice_daa_ctrl_regs
   import daa_ctrl_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Line-side events, asynchronous
   input  wire logic              billingToneEvent,
   input  wire logic              rxOverloadEvent,
   // Control to the line interface
   output var  line_ctrl_type     lineCtrl,
   output var  logic              holdOffhook,
   output var  logic              calStartPulse,
   output var  logic              calDiscardPulse,
   output var  logic              irq
);

   // Stored control bits
   logic [7:0]        gainOne_r;
   logic [7:0]        lineOne_r;
   logic [7:0]        lineTwo_r;
   logic [IRQ_W-1:0]  irqStat_r;
   logic [IRQ_W-1:0]  irqEn_r;
   logic [1:0]        btSync_r;
   logic [1:0]        ovSync_r;
   logic              btSeen_r;
   logic              ovSeen_r;

   // Write channel capture
   logic              awHeld_r;
   logic              wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [7:0]        wByte_r;
   logic              wLane_r;
   logic              arHeld_r;

   // Byte address is four times the index, so the word index is a[7:2]
   function automatic logic hitAddr(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
      hitAddr = (a[7:2] == idx[5:0]);
   endfunction

   // Write decode, one write performed when address and data both held
   wire        doWrite   = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire        wrEn      = doWrite && wLane_r;
   wire        wrGain    = wrEn && hitAddr(awAddr_r, IDX_GAIN_ONE);
   wire        wrLineOne = wrEn && hitAddr(awAddr_r, IDX_LINE_ONE);
   wire        wrLineTwo = wrEn && hitAddr(awAddr_r, IDX_LINE_TWO);
   wire        wrIrqEn   = wrEn && hitAddr(awAddr_r, IDX_IRQ_EN);
   wire        wrIrqClr  = wrEn && hitAddr(awAddr_r, IDX_IRQ_CLR);
   wire        wrMapped  = hitAddr(awAddr_r, IDX_GAIN_ONE) ||
                           hitAddr(awAddr_r, IDX_LINE_ONE) ||
                           hitAddr(awAddr_r, IDX_LINE_TWO) ||
                           hitAddr(awAddr_r, IDX_IRQ_STAT) ||
                           hitAddr(awAddr_r, IDX_IRQ_EN)   ||
                           hitAddr(awAddr_r, IDX_IRQ_CLR);

   // Event edges, read only from the second synchroniser stage
   wire        btRise    = btSync_r[1] && !btSeen_r;
   wire        ovRise    = ovSync_r[1] && !ovSeen_r;

   // R16: clearing the enable also clears the flag
   wire        bteCleared = wrLineTwo && !wByte_r[BTE_BIT];
   // R18: writing zero to the overload flag clears it
   wire        rovCleared = wrLineTwo && !wByte_r[ROV_BIT];
   // R15: only detected while billing tone detection is enabled
   wire        btSet      = btRise && lineTwo_r[BTE_BIT];

   logic [7:0] lineTwoNxt;
   always_comb begin
      lineTwoNxt = lineTwo_r;
      if (wrLineTwo) begin
         lineTwoNxt[7:2] = wByte_r[7:2];
         lineTwoNxt[ROV_BIT] = lineTwo_r[ROV_BIT] & wByte_r[ROV_BIT];
      end
      if (bteCleared) begin
         lineTwoNxt[BTD_BIT] = 1'b0;
      end
      // R15: a new event wins over a clear in the same cycle
      if (btSet) begin
         lineTwoNxt[BTD_BIT] = 1'b1;
      end
      // R18: overload event sets the flag, winning over clear
      if (ovRise) begin
         lineTwoNxt[ROV_BIT] = 1'b1;
      end
   end

   logic [IRQ_W-1:0] irqStatNxt;
   always_comb begin
      irqStatNxt = irqStat_r;
      if (wrIrqClr) begin
         irqStatNxt = irqStat_r & ~wByte_r[IRQ_W-1:0];
      end
      // R18: clearing the flag also clears its interrupt bit
      if (rovCleared) begin
         irqStatNxt[IRQ_ROV_BIT] = 1'b0;
      end
      if (bteCleared) begin
         irqStatNxt[IRQ_BTD_BIT] = 1'b0;
      end
      if (ovRise) begin
         irqStatNxt[IRQ_ROV_BIT] = 1'b1;
      end
      if (btSet) begin
         irqStatNxt[IRQ_BTD_BIT] = 1'b1;
      end
   end

   // Read decode
   // R19: reserved bits read as zero through the masks
   wire [7:0]  rdByte =
      hitAddr(s_axi_araddr, IDX_GAIN_ONE) ? (gainOne_r & GAIN_ONE_MASK) :
      hitAddr(s_axi_araddr, IDX_LINE_ONE) ? (lineOne_r & LINE_ONE_MASK) :
      hitAddr(s_axi_araddr, IDX_LINE_TWO) ? lineTwo_r :
      hitAddr(s_axi_araddr, IDX_IRQ_STAT) ? {6'h00, irqStat_r} :
      hitAddr(s_axi_araddr, IDX_IRQ_EN)   ? {6'h00, irqEn_r} : 8'h00;
   wire        rdMapped = hitAddr(s_axi_araddr, IDX_GAIN_ONE) ||
                          hitAddr(s_axi_araddr, IDX_LINE_ONE) ||
                          hitAddr(s_axi_araddr, IDX_LINE_TWO) ||
                          hitAddr(s_axi_araddr, IDX_IRQ_STAT) ||
                          hitAddr(s_axi_araddr, IDX_IRQ_EN)   ||
                          hitAddr(s_axi_araddr, IDX_IRQ_CLR);
   wire        rdTake   = s_axi_arvalid && s_axi_arready;

   // AXI write handshake
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= '0;
         wByte_r       <= 8'h00;
         wLane_r       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wByte_r <= s_axi_wdata[7:0];
            wLane_r <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read handshake
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         arHeld_r      <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !arHeld_r && !s_axi_arready && s_axi_arvalid
                          && !s_axi_rvalid;
         if (rdTake) begin
            arHeld_r     <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rdByte};
            s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            arHeld_r     <= 1'b0;
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register storage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gainOne_r <= REG_RESET;
         lineOne_r <= REG_RESET;
         lineTwo_r <= REG_RESET;
         irqStat_r <= '0;
         irqEn_r   <= '0;
      end else begin
         // R17: reserved bits stored but steer nothing
         if (wrGain) begin
            gainOne_r <= wByte_r;
         end
         if (wrLineOne) begin
            lineOne_r <= wByte_r;
         end
         if (wrIrqEn) begin
            irqEn_r <= wByte_r[IRQ_W-1:0];
         end
         lineTwo_r <= lineTwoNxt;
         irqStat_r <= irqStatNxt;
      end
   end

   // Event synchronisers and edge memory
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         btSync_r <= 2'b00;
         ovSync_r <= 2'b00;
         btSeen_r <= 1'b0;
         ovSeen_r <= 1'b0;
      end else begin
         btSync_r <= {btSync_r[0], billingToneEvent};
         ovSync_r <= {ovSync_r[0], rxOverloadEvent};
         btSeen_r <= btSync_r[1];
         ovSeen_r <= ovSync_r[1];
      end
   end

   // Control outputs, registered from the stored bits, the write decode and the next interrupt status
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lineCtrl        <= '0;
         holdOffhook     <= 1'b0;
         calStartPulse   <= 1'b0;
         calDiscardPulse <= 1'b0;
         irq             <= 1'b0;
      end else begin
         // R1: transmit mute
         lineCtrl.transmitMute         <= gainOne_r[TXMUTE_BIT];
         // R2: receive mute
         lineCtrl.receiveMute          <= gainOne_r[RXMUTE_BIT];
         // R3: local speed bit, combined with remote bits downstream
         lineCtrl.onhookSpeedSel       <= lineOne_r[OHSPEED_BIT];
         // R4: filter type for both paths
         lineCtrl.iirFilterSelect      <= lineOne_r[IIR_BIT];
         // R5: ringer impedance
         lineCtrl.ringerImpedanceSynth <= lineOne_r[RZ_BIT];
         // R6: ring window, pattern 01 left to software to avoid
         lineCtrl.ringLevelSel         <= {lineOne_r[RLA_BIT], lineTwo_r[RLB_BIT]};
         // R9: level held while set; software returns it to zero
         lineCtrl.adcCalClear          <= lineTwo_r[CALCLR_BIT];
         // R11: manual calibration request level
         lineCtrl.manualAdcCal         <= lineTwo_r[MANUAL_ADC_CAL_BIT];
         // R12: automatic calibration disable
         lineCtrl.autoCalDisable       <= lineTwo_r[CALDIS_BIT];
         // R13: overload protection
         lineCtrl.overloadGuardEn      <= lineTwo_r[OVG_BIT];
         lineCtrl.billingToneEnable    <= lineTwo_r[BTE_BIT];
         // R14: ride through supply disruption while enabled
         holdOffhook     <= lineTwo_r[BTE_BIT];
         // R11: one pulse per write of one
         calStartPulse   <= wrLineTwo && wByte_r[MANUAL_ADC_CAL_BIT];
         // R9: one pulse per write of one
         calDiscardPulse <= wrLineTwo && wByte_r[CALCLR_BIT];
         irq             <= |(irqStatNxt & irqEn_r);
      end
   end

endmodule // voice_daa_ctrl_regs
`default_nettype wire

// ==== daa_ctrl_pkg.sv ====
/*
 Package for the line-interface control register bank: register offsets,
 field positions, reset values and AXI4-Lite response codes.
 Assumes a 32-bit AXI4-Lite bus with byte addresses on word boundaries.
*/
package daa_ctrl_pkg;

   localparam int        ADDR_W          = 8;
   // Printed offsets are not all multiples of four: they are word indices
   localparam logic [7:0] IDX_GAIN_ONE   = 8'h0F;
   localparam logic [7:0] IDX_LINE_ONE   = 8'h10;
   localparam logic [7:0] IDX_LINE_TWO   = 8'h11;
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h20;
   localparam logic [7:0] IDX_IRQ_EN     = 8'h21;
   localparam logic [7:0] IDX_IRQ_CLR    = 8'h22;

   // Gain control one fields
   localparam int        TXMUTE_BIT      = 7;
   localparam int        RXMUTE_BIT      = 3;
   // Line option control one fields
   localparam int        OHSPEED_BIT     = 6;
   localparam int        IIR_BIT         = 4;
   localparam int        RZ_BIT          = 1;
   localparam int        RLA_BIT         = 0;
   localparam logic [7:0] LINE_ONE_MASK  = 8'hF3;
   localparam logic [7:0] GAIN_ONE_MASK  = 8'h88;
   // Line option control two fields
   localparam int        CALCLR_BIT      = 7;
   localparam int        MANUAL_ADC_CAL_BIT        = 6;
   localparam int        CALDIS_BIT      = 5;
   localparam int        RLB_BIT         = 4;
   localparam int        OVG_BIT         = 3;
   localparam int        BTE_BIT         = 2;
   localparam int        ROV_BIT         = 1;
   localparam int        BTD_BIT         = 0;
   // Interrupt status fields
   localparam int        IRQ_ROV_BIT     = 0;
   localparam int        IRQ_BTD_BIT     = 1;
   localparam int        IRQ_W           = 2;

   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   typedef struct packed {
      logic transmitMute;
      logic receiveMute;
      logic onhookSpeedSel;
      logic iirFilterSelect;
      logic ringerImpedanceSynth;
      logic [1:0] ringLevelSel;
      logic adcCalClear;
      logic manualAdcCal;
      logic autoCalDisable;
      logic overloadGuardEn;
      logic billingToneEnable;
   } line_ctrl_type;

   typedef struct packed {
      logic billingTone;
      logic rxOverload;
   } line_event_type;

endpackage

// ==== voice_daa_ctrl_regs_properties.sv ====
/* Checker for the control register bank: bus answers, pulse shape, hold.
   Assumes binding to every voice_daa_ctrl_regs; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module voice_daa_ctrl_regs_properties
   import daa_ctrl_pkg::*;
(
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire logic          s_axi_awvalid,
   input wire logic          s_axi_awready,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic [1:0]    s_axi_bresp,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_rready,
   input wire logic          calStartPulse,
   input wire logic          calDiscardPulse,
   input wire logic          holdOffhook,
   input wire line_ctrl_type lineCtrl
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
   a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("rdata upper bits set");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("write answer late");
   a_cal_start_pulse: assert property (calStartPulse |=> !calStartPulse)
      else $error("calibration start too long");
   a_cal_clear_pulse: assert property (calDiscardPulse |=> !calDiscardPulse)
      else $error("calibration clear too long");
   a_hold_follows_enable: assert property ($changed(holdOffhook) |-> $past(s_axi_bvalid) &&
      holdOffhook == lineCtrl.billingToneEnable) else $error("hold differs from enable");
endmodule // voice_daa_ctrl_regs_properties
bind voice_daa_ctrl_regs voice_daa_ctrl_regs_properties voice_daa_ctrl_regs_properties_i (
   .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .calStartPulse(calStartPulse),
   .calDiscardPulse(calDiscardPulse), .holdOffhook(holdOffhook), .lineCtrl(lineCtrl));
`default_nettype wire

// ==== voice_daa_ctrl_regs_tb.sv ====
/* Self-checking bench for the control register bank over AXI4-Lite.
   Assumes the package byte addresses: 0x3C, 0x40, 0x44, status 0x80. */
`timescale 1ns/1ps
`default_nettype none
module voice_daa_ctrl_regs_tb
   import daa_ctrl_pkg::*;
;
   typedef struct {logic [7:0] a, d, r; logic [1:0] resp; logic [11:0] lc;} row_type;
   logic          sys_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic          arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [7:0]    awaddr = 0, araddr = 0;
   logic [31:0]   wdata = 0, rdata;
   logic [1:0]    bresp, rresp;
   logic [3:0]    wstrb = 4'hF;
   logic          btEv = 0, ovEv = 0, hold, calStart, calDisc, irq;
   line_ctrl_type lineCtrl;
   int            err_total = 0, compares = 0, nStart = 0, nDisc = 0, n;
   row_type       rows [7] = '{
      '{8'h3C, 8'hFF, 8'h88, RESP_OKAY, 12'hC00}, '{8'h40, 8'hFF, 8'hF3, RESP_OKAY, 12'hFC0},
      '{8'h44, 8'h3C, 8'h3C, RESP_OKAY, 12'hFE7}, '{8'h3C, 8'h00, 8'h00, RESP_OKAY, 12'h3E7},
      // line two cleared before line one, so ring pattern 01 never appears
      '{8'h44, 8'h00, 8'h00, RESP_OKAY, 12'h3C0}, '{8'h40, 8'h00, 8'h00, RESP_OKAY, 12'h000},
      '{8'h48, 8'hFF, 8'h00, RESP_SLVERR, 12'h000}};

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      nStart += calStart;
      nDisc += calDisc;
   end

   voice_daa_ctrl_regs voice_daa_ctrl_regs_i (.sys_clk(sys_clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .billingToneEvent(btEv), .rxOverloadEvent(ovEv), .lineCtrl(lineCtrl),
      .holdOffhook(hold), .calStartPulse(calStart), .calDiscardPulse(calDisc), .irq(irq));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      n = 0;
      // Each valid drops at its own handshake edge; the loop ends at the first edge that sees bvalid
      do begin
         @(posedge sys_clk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (n < 50 && !bvalid);
      chk({bvalid, bresp}, {1'b1, er});
      bready <= 0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (arready) arvalid <= 0;
      end while (n < 50 && !rvalid);
      chk(rdata, {24'h0, e});
      chk({rvalid, rresp}, {1'b1, er});
      rready <= 0;
      @(posedge sys_clk);
   endtask

   // Events are held well past the three-cycle synchroniser minimum
   task automatic ev(input logic bt);
      if (bt) btEv <= 1;
      else ovEv <= 1;
      repeat (6) @(posedge sys_clk);
      btEv <= 0;
      ovEv <= 0;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic stop_test();
      $display("err_total=%0d compares=%0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].resp);
         rd(rows[i].a, rows[i].r, rows[i].resp);
         chk(lineCtrl, rows[i].lc);
      end
      wr(8'h3C, 8'h80);
      wr(8'h40, 8'h10);
      chk(lineCtrl, 12'h900);
      rst <= 1;
      @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      rd(8'h3C, 8'h00);
      rd(8'h40, 8'h00);
      chk(lineCtrl, 0);
      // A write without byte lane zero must leave the register alone
      wstrb <= 4'h0;
      wr(8'h3C, 8'hFF);
      wstrb <= 4'hF;
      rd(8'h3C, 8'h00);
      chk(lineCtrl, 0);
      wr(8'h44, 8'hC0);
      wr(8'h44, 8'h00);
      chk(nStart, 1);
      chk(nDisc, 1);
      wr(8'h84, 8'h03);
      ev(1);
      rd(8'h44, 8'h00);
      wr(8'h44, 8'h04);
      chk(hold, 1);
      ev(1);
      rd(8'h44, 8'h05);
      rd(8'h80, 8'h02);
      chk(irq, 1);
      wr(8'h44, 8'h00);
      rd(8'h44, 8'h00);
      rd(8'h80, 8'h00);
      chk({hold, irq}, 0);
      ev(0);
      rd(8'h44, 8'h02);
      rd(8'h80, 8'h01);
      chk(irq, 1);
      wr(8'h84, 8'h00);
      chk(irq, 0);
      wr(8'h84, 8'h03);
      wr(8'h44, 8'h02);
      rd(8'h44, 8'h02);
      wr(8'h44, 8'h00);
      rd(8'h44, 8'h00);
      rd(8'h80, 8'h00);
      ev(0);
      wr(8'h88, 8'h01);
      rd(8'h80, 8'h00);
      rd(8'h88, 8'h00);
      rd(8'h44, 8'h02);
      chk(irq, 0);
      stop_test();
   end

   // Whole sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      stop_test();
   end
endmodule // voice_daa_ctrl_regs_tb
`default_nettype wire
